/* File: sbh_pkg.sv */
/*
  Constants and shared types of the serial boot command handler: command
  and acknowledge codes, address windows, byte counts and flash operations.
  Assumes the byte-level receiver, transmitter and flash controller share
  the core clock with the handler.
*/
package sbh_pkg;

  // Command bytes; sum and product-information codes are free choices
  localparam logic [7:0] BAUD_CODE = 8'h86;
  localparam logic [7:0] CMD_RAM   = 8'h10;
  localparam logic [7:0] CMD_SUM   = 8'h20;
  localparam logic [7:0] CMD_INFO  = 8'h30;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] ERASE_KEY = 8'h54;
  localparam logic [7:0] CMD_PROG  = 8'h50;
  localparam logic [7:0] CMD_PSET  = 8'h60;

  // Result acknowledges
  localparam logic [7:0] ER_OK     = 8'h4F;
  localparam logic [7:0] ER_BAD    = 8'h4C;
  localparam logic [7:0] ER_END_OK = 8'h5D;
  localparam logic [7:0] ER_END_BAD = 8'h60;
  localparam logic [7:0] PS_OK     = 8'h6F;
  localparam logic [7:0] PS_BAD    = 8'h6C;
  localparam logic [7:0] PD_OK     = 8'h31;
  localparam logic [7:0] PD_BAD    = 8'h34;

  // Low nibbles of error acknowledges
  localparam logic [3:0] NIB_CMD   = 4'h1;
  localparam logic [3:0] NIB_ERASE = 4'h4;
  localparam logic [3:0] NIB_PROT  = 4'h6;
  localparam logic [3:0] NIB_RX    = 4'h8;

  // Flash and RAM windows
  localparam logic [31:0] PW_BASE   = 32'h0004FEF4;
  localparam logic [31:0] INFO_BASE = 32'h0004FEF0;
  localparam logic [31:0] ROM_LO    = 32'h00010000;
  localparam logic [31:0] ROM_HI    = 32'h0004FFFF;
  localparam logic [31:0] RAM_LO    = 32'h00001000;
  localparam logic [31:0] RAM_HI    = 32'h00004DFF;
  localparam logic [15:0] LEN_MAX   = 16'h0400;
  localparam int          FLASH_BYTES = 262144;

  // Byte counter width and last indices of fixed-length fields
  localparam int          CNT_W     = 18;
  localparam logic [17:0] PW_LAST   = 18'h0000B;
  localparam logic [17:0] ADDR_LAST = 18'h00003;
  localparam logic [17:0] HDR_LAST  = 18'h00005;
  localparam logic [17:0] INFO_LAST = 18'h00003;

  // Operations requested from the flash controller
  typedef enum logic [1:0] {FL_RD, FL_WR, FL_ERASE, FL_PROT} sbh_fl_op_type;

endpackage

/* File: sbh_txbuf.sv */
/*
  Two-entry buffer in the acknowledge path: a head register that drives
  the outputs and one skid entry. Assumes both sides run on core_clk.
*/
`timescale 1ns/1ps
module sbh_txbuf #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  typedef struct packed {
    logic         hv;
    logic [W-1:0] hd;
    logic         sv;
    logic [W-1:0] sd;
  } sbh_buf_type;

  sbh_buf_type s_ff;
  sbh_buf_type nxt_s;
  logic        acc;
  logic        pop;

  // Skid full means the source must stall: ready comes from that flop
  assign acc       = in_valid && !s_ff.sv;
  assign pop       = s_ff.hv && out_ready;
  assign in_ready  = !s_ff.sv;
  assign out_valid = s_ff.hv;
  assign out_data  = s_ff.hd;

  // Head refills from the skid entry first to keep byte order
  always_comb begin
    nxt_s = s_ff;
    if (!s_ff.hv || pop) begin
      if (s_ff.sv) begin
        nxt_s.hd = s_ff.sd;
        nxt_s.hv = 1'b1;
        nxt_s.sv = 1'b0;
      end else begin
        nxt_s.hv = acc;
        nxt_s.hd = in_data;
      end
    end else if (acc) begin
      nxt_s.sv = 1'b1;
      nxt_s.sd = in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

/* File: sbh_handler.sv */
/*
  Serial boot command handler: byte-level command interpreter between the
  serial receiver/transmitter and the flash controller and internal RAM.
  Assumes a receiver on core_clk handing over whole bytes with an error
  flag, a flash controller answering each request with a one-cycle ack,
  and protection status levels from the flash option logic.
*/
//
// Contract
// - After reset in serial boot mode, run the handler and serve controller commands.
// - Echo 86H for the baud byte if rate reachable; otherwise stop silently.
// - After any error acknowledge, wait for a new operation command byte.
// - Refuse program command until chip erase 40H has completed this session.
// - Abort program command while read or write protection is active.
// - Echo 60H for protect-set; unknown command gets x1H, receive error x8H.
// - Password checksum acknowledge: 60H good, 61H checksum/password error, 68H receive error.
// - After good password, report protect-set result: 6FH success, 6CH failure.
// - Refuse protect-set when the supplied password mismatches the stored one.
// - Protect-set enables both read and write protection.
// - Read protection blocks flash reads, write protection blocks flash writes; sum and product-information reads here ignore prot_rd.
// - RAM transfer stores bytes into internal RAM, limited to 15.8 Kbytes; the code's window 1000H..4DFFH holds 15.5 Kbytes.
// - After RAM transfer, execute from the controller-given RAM start address.
// - No RAM transfer under protection or on password failure.
// - Sum command adds all 256 Kbytes of flash and returns the result.
// - Product-information read returns flash bytes 04FEF0H through 04FEF3H.
// - Chip erase erases every sector and clears any protection.
// - Chip erase needs no password check.
// - Compare 12 password bytes in order with flash 04FEF4H..04FEFFH.
// - Error acknowledge upper nibble repeats last received command's upper nibble; the fixed failure codes 34H (protect-set) and 60H (erase) do not.
`timescale 1ns/1ps
module sbh_handler
  import sbh_pkg::*;
#(
  parameter int FLASH_SIZE = sbh_pkg::FLASH_BYTES
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_err,
  output logic                        rx_ready,
  input  wire logic                   baud_ok,
  input  wire logic                   prot_rd,
  input  wire logic                   prot_wr,
  output logic                        tx_valid,
  output logic [7:0]                  tx_data,
  input  wire logic                   tx_ready,
  output logic                        fl_req,
  output sbh_pkg::sbh_fl_op_type      fl_op,
  output logic [31:0]                 fl_addr,
  output logic [7:0]                  fl_wdata,
  input  wire logic                   fl_ack,
  input  wire logic                   fl_fail,
  input  wire logic [7:0]             fl_rdata,
  output logic                        ram_we,
  output logic [31:0]                 ram_addr,
  output logic [7:0]                  ram_wdata,
  output logic                        exec_start,
  output logic [31:0]                 exec_addr,
  output logic                        erased
);

  typedef enum logic [4:0] {
    S_BAUD, S_STOP, S_CMD, S_SEND, S_PW, S_PWRD, S_PWCS, S_PROT, S_PDONE,
    S_HDR, S_HDRCS, S_DATA, S_WR, S_DCS, S_EXEC, S_ERKEY, S_ERASE, S_EDONE,
    S_SUM, S_SUMRD, S_SUMLO, S_INFO, S_INFORD
  } sbh_state_type;

  typedef struct packed {
    logic          vld;
    logic [7:0]    ack;
    logic          err;
    sbh_state_type after;
  } sbh_send_type;

  typedef struct packed {
    sbh_state_type  st;
    sbh_state_type  after;
    logic [7:0]     ack;
    logic           err;
    logic [3:0]     hi;
    logic [7:0]     cmd;
    logic           erased;
    logic           pw_bad;
    logic           bad;
    logic           fail;
    logic [7:0]     sum;
    logic [CNT_W-1:0] cnt;
    logic [31:0]    addr;
    logic [31:0]    base;
    logic [15:0]    len;
    logic [15:0]    acc;
    logic           tx_v;
    logic [7:0]     tx_d;
    logic           rx_rdy;
    logic           fl_req;
    sbh_fl_op_type  fl_op;
    logic [31:0]    fl_addr;
    logic [7:0]     fl_wd;
    logic           ram_we;
    logic [31:0]    ram_addr;
    logic [7:0]     ram_wd;
    logic           exec;
    logic [31:0]    exec_addr;
  } sbh_st_type;

  sbh_st_type   s_ff;
  sbh_st_type   nxt_s;
  sbh_send_type req;
  logic         take;
  logic         tx_in_rdy;
  logic         prot;
  logic [31:0]  last_addr;
  logic         hdr_ok;

  function automatic sbh_send_type mk(input logic [7:0] a, input logic e, input sbh_state_type nx);
    return '{vld: 1'b1, ack: a, err: e, after: nx};
  endfunction

  assign take      = rx_valid && s_ff.rx_rdy;
  assign prot      = prot_rd || prot_wr;
  assign last_addr = s_ff.addr + {16'h0000, s_ff.len} - 32'h00000001;

  // Window checks for the header; the controller owes these, we still guard
  always_comb begin
    if (s_ff.cmd == CMD_RAM) begin
      hdr_ok = (s_ff.len != 16'h0000) && (s_ff.addr >= RAM_LO) && (last_addr <= RAM_HI);
    end else begin
      hdr_ok = !s_ff.addr[0] && (s_ff.addr >= ROM_LO) && (last_addr <= ROM_HI)
               && (s_ff.len != 16'h0000) && (s_ff.len <= LEN_MAX);
    end
  end

  // One walk through the command sequence per received or answered byte
  always_comb begin
    nxt_s        = s_ff;
    req          = '0;
    nxt_s.exec   = 1'b0;
    nxt_s.ram_we = 1'b0;
    if (s_ff.tx_v && tx_in_rdy) begin
      nxt_s.tx_v = 1'b0;
    end
    if (fl_ack) begin
      nxt_s.fl_req = 1'b0;
    end
    unique case (s_ff.st)
      S_BAUD: if (take) begin
        if (rx_data == BAUD_CODE && !rx_err && baud_ok) begin
          req = mk(BAUD_CODE, 1'b0, S_CMD);
        end else begin
          nxt_s.st = S_STOP;
        end
      end
      S_STOP: nxt_s.st = S_STOP;
      // Acknowledge leaves only once the buffer has room; later bytes queue
      S_SEND: if (!s_ff.tx_v) begin
        nxt_s.tx_v = 1'b1;
        nxt_s.tx_d = s_ff.ack;
        nxt_s.st   = s_ff.after;
      end
      S_CMD: if (take) begin
        nxt_s.cnt    = '0;
        nxt_s.sum    = 8'h00;
        nxt_s.bad    = 1'b0;
        nxt_s.pw_bad = 1'b0;
        nxt_s.fail   = 1'b0;
        if (rx_err) begin
          req = mk({s_ff.hi, NIB_RX}, 1'b1, S_CMD);
        end else begin
          nxt_s.hi  = rx_data[7:4];
          nxt_s.cmd = rx_data;
          if (rx_data == CMD_RAM) begin
            req = prot ? mk({rx_data[7:4], NIB_PROT}, 1'b1, S_CMD) : mk(rx_data, 1'b0, S_PW);
          end else if (rx_data == CMD_PROG) begin
            if (!s_ff.erased) begin
              req = mk({rx_data[7:4], NIB_ERASE}, 1'b1, S_CMD);
            end else if (prot) begin
              req = mk({rx_data[7:4], NIB_PROT}, 1'b1, S_CMD);
            end else begin
              req = mk(rx_data, 1'b0, S_HDR);
            end
          end else if (rx_data == CMD_PSET) begin
            req = mk(rx_data, 1'b0, S_PW);
          end else if (rx_data == CMD_ERASE) begin
            req = mk(rx_data, 1'b0, S_ERKEY);
          end else if (rx_data == CMD_SUM) begin
            nxt_s.addr = ROM_LO;
            nxt_s.acc  = 16'h0000;
            req        = mk(rx_data, 1'b0, S_SUM);
          end else if (rx_data == CMD_INFO) begin
            nxt_s.addr = INFO_BASE;
            req        = mk(rx_data, 1'b0, S_INFO);
          end else begin
            req = mk({rx_data[7:4], NIB_CMD}, 1'b1, S_CMD);
          end
        end
      end
      // Each password byte is held while its stored counterpart is fetched
      S_PW: if (take) begin
        nxt_s.sum     = s_ff.sum + rx_data;
        nxt_s.bad     = s_ff.bad || rx_err;
        nxt_s.fl_req  = 1'b1;
        nxt_s.fl_op   = FL_RD;
        nxt_s.fl_addr = PW_BASE + 32'(s_ff.cnt);
        nxt_s.fl_wd   = rx_data;
        nxt_s.st      = S_PWRD;
      end
      S_PWRD: if (fl_ack) begin
        nxt_s.pw_bad = s_ff.pw_bad || (fl_rdata != s_ff.fl_wd);
        nxt_s.cnt    = s_ff.cnt + 18'h00001;
        nxt_s.st     = (s_ff.cnt == PW_LAST) ? S_PWCS : S_PW;
      end
      // Receive error outranks checksum, checksum outranks password
      S_PWCS: if (take) begin
        nxt_s.cnt = '0;
        nxt_s.sum = 8'h00;
        nxt_s.bad = 1'b0;
        if (s_ff.bad || rx_err) begin
          req = mk({s_ff.hi, NIB_RX}, 1'b1, S_CMD);
        end else if (8'(s_ff.sum + rx_data) != 8'h00) begin
          req = mk({s_ff.hi, NIB_CMD}, 1'b1, S_CMD);
        end else if (s_ff.pw_bad) begin
          req = mk({s_ff.hi, NIB_CMD}, 1'b1, S_CMD);
        end else if (s_ff.cmd == CMD_RAM) begin
          req = mk(s_ff.cmd, 1'b0, S_HDR);
        end else begin
          req = mk(s_ff.cmd, 1'b0, S_PROT);
        end
      end
      // Request waits for the echo to leave, so a fast ack is never missed in S_SEND
      S_PROT: if (s_ff.cnt == '0) begin
        nxt_s.fl_req = 1'b1;
        nxt_s.fl_op  = FL_PROT;
        nxt_s.cnt    = 18'h00001;
      end else if (fl_ack) begin
        nxt_s.fail = fl_fail;
        req        = mk(fl_fail ? PS_BAD : PS_OK, 1'b0, S_PDONE);
      end
      S_PDONE: req = mk(s_ff.fail ? PD_BAD : PD_OK, s_ff.fail, S_CMD);
      // Four address bytes then two count bytes, most significant first
      S_HDR: if (take) begin
        nxt_s.sum = s_ff.sum + rx_data;
        nxt_s.bad = s_ff.bad || rx_err;
        nxt_s.cnt = s_ff.cnt + 18'h00001;
        if (s_ff.cnt <= ADDR_LAST) begin
          nxt_s.addr = {s_ff.addr[23:0], rx_data};
        end else begin
          nxt_s.len = {s_ff.len[7:0], rx_data};
        end
        if (s_ff.cnt == HDR_LAST) begin
          nxt_s.st = S_HDRCS;
        end
      end
      S_HDRCS: if (take) begin
        nxt_s.cnt  = '0;
        nxt_s.sum  = 8'h00;
        nxt_s.bad  = 1'b0;
        nxt_s.base = s_ff.addr;
        if (s_ff.bad || rx_err) begin
          req = mk({s_ff.hi, NIB_RX}, 1'b1, S_CMD);
        end else if (8'(s_ff.sum + rx_data) != 8'h00 || !hdr_ok) begin
          req = mk({s_ff.hi, NIB_CMD}, 1'b1, S_CMD);
        end else begin
          req = mk(s_ff.cmd, 1'b0, S_DATA);
        end
      end
      S_DATA: if (take) begin
        nxt_s.sum = s_ff.sum + rx_data;
        nxt_s.bad = s_ff.bad || rx_err;
        if (s_ff.cmd == CMD_RAM) begin
          nxt_s.ram_we   = 1'b1;
          nxt_s.ram_addr = s_ff.addr;
          nxt_s.ram_wd   = rx_data;
          nxt_s.addr     = s_ff.addr + 32'h00000001;
          nxt_s.cnt      = s_ff.cnt + 18'h00001;
          if (s_ff.cnt == {2'b00, s_ff.len} - 18'h00001) begin
            nxt_s.st = S_DCS;
          end
        end else begin
          nxt_s.fl_req  = 1'b1;
          nxt_s.fl_op   = FL_WR;
          nxt_s.fl_addr = s_ff.addr;
          nxt_s.fl_wd   = rx_data;
          nxt_s.st      = S_WR;
        end
      end
      S_WR: if (fl_ack) begin
        nxt_s.fail = s_ff.fail || fl_fail;
        nxt_s.addr = s_ff.addr + 32'h00000001;
        nxt_s.cnt  = s_ff.cnt + 18'h00001;
        nxt_s.st   = (s_ff.cnt == {2'b00, s_ff.len} - 18'h00001) ? S_DCS : S_DATA;
      end
      S_DCS: if (take) begin
        if (s_ff.bad || rx_err) begin
          req = mk({s_ff.hi, NIB_RX}, 1'b1, S_CMD);
        end else if (8'(s_ff.sum + rx_data) != 8'h00 || s_ff.fail) begin
          req = mk({s_ff.hi, NIB_CMD}, 1'b1, S_CMD);
        end else begin
          req = mk(s_ff.cmd, 1'b0, (s_ff.cmd == CMD_RAM) ? S_EXEC : S_CMD);
        end
      end
      // Control passes to the loaded program; the handler goes quiet
      S_EXEC: begin
        nxt_s.exec      = 1'b1;
        nxt_s.exec_addr = s_ff.base;
        nxt_s.st        = S_STOP;
      end
      S_ERKEY: if (take) begin
        if (rx_err) begin
          req = mk({s_ff.hi, NIB_RX}, 1'b1, S_CMD);
        end else if (rx_data != ERASE_KEY) begin
          req = mk({s_ff.hi, NIB_CMD}, 1'b1, S_CMD);
        end else begin
          req = mk(ERASE_KEY, 1'b0, S_ERASE);
        end
      end
      // Count is zero from the command byte: first cycle raises the request
      S_ERASE: if (s_ff.cnt == '0) begin
        nxt_s.fl_req = 1'b1;
        nxt_s.fl_op  = FL_ERASE;
        nxt_s.cnt    = 18'h00001;
      end else if (fl_ack) begin
        nxt_s.fail   = fl_fail;
        nxt_s.erased = s_ff.erased || !fl_fail;
        req          = mk(fl_fail ? ER_BAD : ER_OK, 1'b0, S_EDONE);
      end
      S_EDONE: req = mk(s_ff.fail ? ER_END_BAD : ER_END_OK, s_ff.fail, S_CMD);
      // Whole-array sum, one read per byte; long but keeps the port simple
      S_SUM: begin
        nxt_s.fl_req  = 1'b1;
        nxt_s.fl_op   = FL_RD;
        nxt_s.fl_addr = s_ff.addr;
        nxt_s.st      = S_SUMRD;
      end
      S_SUMRD: if (fl_ack) begin
        nxt_s.acc  = s_ff.acc + {8'h00, fl_rdata};
        nxt_s.addr = s_ff.addr + 32'h00000001;
        nxt_s.cnt  = s_ff.cnt + 18'h00001;
        if (s_ff.cnt == CNT_W'(FLASH_SIZE - 1)) begin
          req = mk(8'(({8'h00, fl_rdata} + s_ff.acc) >> 8), 1'b0, S_SUMLO);
        end else begin
          nxt_s.st = S_SUM;
        end
      end
      S_SUMLO: req = mk(s_ff.acc[7:0], 1'b0, S_CMD);
      S_INFO: begin
        nxt_s.fl_req  = 1'b1;
        nxt_s.fl_op   = FL_RD;
        nxt_s.fl_addr = s_ff.addr;
        nxt_s.st      = S_INFORD;
      end
      S_INFORD: if (fl_ack) begin
        nxt_s.addr = s_ff.addr + 32'h00000001;
        nxt_s.cnt  = s_ff.cnt + 18'h00001;
        req        = mk(fl_rdata, 1'b0, (s_ff.cnt == INFO_LAST) ? S_CMD : S_INFO);
      end
    endcase
    if (req.vld) begin
      nxt_s.ack   = req.ack;
      nxt_s.err   = req.err;
      nxt_s.after = req.after;
      nxt_s.st    = S_SEND;
    end
    nxt_s.rx_rdy = nxt_s.st inside {S_BAUD, S_CMD, S_PW, S_PWCS, S_HDR, S_HDRCS, S_DATA, S_DCS, S_ERKEY};
  end

  // Reset lands in baud detection: the handler is live from the start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  sbh_txbuf #(.W(8)) u_txbuf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (s_ff.tx_v),
    .in_data   (s_ff.tx_d),
    .in_ready  (tx_in_rdy),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  assign rx_ready   = s_ff.rx_rdy;
  assign fl_req     = s_ff.fl_req;
  assign fl_op      = s_ff.fl_op;
  assign fl_addr    = s_ff.fl_addr;
  assign fl_wdata   = s_ff.fl_wd;
  assign ram_we     = s_ff.ram_we;
  assign ram_addr   = s_ff.ram_addr;
  assign ram_wdata  = s_ff.ram_wd;
  assign exec_start = s_ff.exec;
  assign exec_addr  = s_ff.exec_addr;
  assign erased     = s_ff.erased;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence baud_good;
    s_ff.st == S_BAUD && take && rx_data == BAUD_CODE && !rx_err && baud_ok;
  endsequence
  sequence cmd_in(logic [7:0] c);
    s_ff.st == S_CMD && take && !rx_err && rx_data == c;
  endsequence

  a_baud_echo: assert property (baud_good |-> ##[1:3] (s_ff.tx_v && s_ff.tx_d == BAUD_CODE))
    else $error("baud byte not echoed");
  a_baud_stop: assert property (s_ff.st == S_BAUD && take && !(rx_data == BAUD_CODE && !rx_err && baud_ok)
    |=> s_ff.st == S_STOP [*3])
    else $error("bad baud byte did not stop");
  a_err_home: assert property (s_ff.st == S_SEND && s_ff.err && !s_ff.tx_v |=> s_ff.st == S_CMD)
    else $error("error ack not followed by command wait");
  a_prog_erase: assert property (cmd_in(CMD_PROG) and (!s_ff.erased)
    |=> s_ff.ack == {CMD_PROG[7:4], NIB_ERASE} && s_ff.after == S_CMD)
    else $error("program accepted before erase");
  a_prog_prot: assert property (cmd_in(CMD_PROG) and (s_ff.erased && prot)
    |=> s_ff.ack == {CMD_PROG[7:4], NIB_PROT} && s_ff.err)
    else $error("program accepted under protection");
  a_rx_nibble: assert property (s_ff.st == S_CMD && take && rx_err
    |=> s_ff.ack == {$past(s_ff.hi), NIB_RX})
    else $error("receive error ack nibble wrong");
  a_pset_echo: assert property (cmd_in(CMD_PSET) |=> s_ff.ack == CMD_PSET ##1 s_ff.tx_d == CMD_PSET)
    else $error("protect-set not echoed");
  a_pw_addr: assert property (s_ff.st == S_PWRD && s_ff.fl_req |-> s_ff.fl_addr == PW_BASE + 32'(s_ff.cnt))
    else $error("password fetched from wrong address");
  a_ram_window: assert property (s_ff.ram_we |-> s_ff.ram_addr >= RAM_LO && s_ff.ram_addr <= RAM_HI)
    else $error("RAM write outside window");
  a_exec_base: assert property (s_ff.st == S_EXEC |=> s_ff.exec && s_ff.exec_addr == s_ff.base)
    else $error("execution start address wrong");
  a_ram_prot: assert property (cmd_in(CMD_RAM) and prot |=> s_ff.err && s_ff.after == S_CMD)
    else $error("RAM transfer under protection");
  a_erase_open: assert property (cmd_in(CMD_ERASE) |=> s_ff.ack == CMD_ERASE && s_ff.after == S_ERKEY)
    else $error("erase refused");

endmodule

/* File: sbh_flash_model.sv */
/* Flash array and option-bit model on the handler's flash port.
   Assumes core_clk and rst_n are shared with the handler. */
`timescale 1ns/1ps
module sbh_flash_model
  import sbh_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   fl_req,
  input  wire sbh_pkg::sbh_fl_op_type fl_op,
  input  wire logic [31:0]            fl_addr,
  output logic                        fl_ack,
  output logic [7:0]                  fl_rdata,
  output logic                        prot_rd,
  output logic                        prot_wr
);
  logic [1:0] wait_ff;
  // Fixed latency; read data churns outside acks so stale bytes show
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {fl_ack, wait_ff, fl_rdata, prot_rd, prot_wr} <= '0;
    end else begin
      fl_ack   <= 1'b0;
      fl_rdata <= ~fl_rdata;
      if (fl_req && !fl_ack && wait_ff == 2'h2) begin
        fl_ack   <= 1'b1;
        wait_ff  <= 2'h0;
        fl_rdata <= fl_addr[7:0] ^ 8'hA5;
        if (fl_op == FL_PROT) {prot_rd, prot_wr} <= 2'h3;
        if (fl_op == FL_ERASE) {prot_rd, prot_wr} <= 2'h0;
      end else if (fl_req && !fl_ack) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule

/* File: tb_sbh_handler.sv */
/* Self-checking bench: plays the programming controller on the byte ports.
   Assumes sbh_pkg and the flash model; transmitter never stalls. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_sbh_handler;
  import sbh_pkg::*;
  logic          core_clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_err = 1'b0;
  logic          baud_ok = 1'b1, tx_ready = 1'b1, fl_fail = 1'b0;
  logic [7:0]    rx_data = 8'h00, tx_data, fl_rdata, fl_wdata, ram_wdata;
  logic          rx_ready, tx_valid, fl_req, fl_ack, prot_rd, prot_wr, erased, ram_we, exec_start;
  logic [31:0]   fl_addr, ram_addr, exec_addr;
  sbh_fl_op_type fl_op;
  int            fails = 0, samples_checked = 0, ram_n = 0, execs = 0;
  logic [7:0]    q[$];
  logic [15:0]   s;
  sbh_handler #(.FLASH_SIZE(16)) DUT (.*);
  sbh_flash_model FM (.*);
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // Pulsed side outputs checked while they stand; data follows the stimulus
  always @(posedge core_clk) begin
    if (fl_ack && fl_op == FL_WR) `CHK(fl_wdata, 8'hAA ^ {8{fl_addr[0]}})
    if (ram_we) begin
      `CHK(ram_addr, 32'h00001000 + ram_n)
      `CHK(ram_wdata, 8'h3C ^ {8{ram_addr[0]}})
      ram_n++;
    end
    if (exec_start) begin
      `CHK(exec_addr, 32'h00001000)
      execs++;
    end
  end
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Offer one byte, hold it until taken, then idle one edge
  task automatic put(input logic [7:0] b, input logic e = 1'b0);
    int n = 0;
    rx_data <= b; rx_err <= e; rx_valid <= 1'b1;
    do begin @(posedge core_clk); n++; end while (rx_ready !== 1'b1 && n < 900);
    rx_valid <= 1'b0; rx_data <= ~b;
    @(posedge core_clk);
    if (n >= 900) begin fails++; conclude(); end
  endtask
  // Wait for the next acknowledge and compare it
  task automatic get(input logic [7:0] e);
    int n = 0;
    do begin @(posedge core_clk); n++; end while (tx_valid !== 1'b1 && n < 900);
    if (n >= 900) begin fails++; conclude(); end
    `CHK(tx_data, e)
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] e);
    put(c); get(e);
  endtask
  // Queue then its checksum; adj spoils the checksum
  task automatic blk(input logic [7:0] adj);
    logic [7:0] c = 8'h00;
    foreach (q[i]) begin put(q[i]); c += q[i]; end
    put(8'h00 - c + adj);
  endtask
  task automatic pw(input logic [7:0] x, input logic [7:0] adj);
    q = {};
    for (int i = 0; i < 12; i++) q.push_back((8'hF4 + 8'(i)) ^ 8'hA5);
    q[0] ^= x;
    blk(adj);
  endtask
  task automatic erase();
    cmd(CMD_ERASE, CMD_ERASE); cmd(ERASE_KEY, ERASE_KEY); get(ER_OK); get(ER_END_OK);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmd(BAUD_CODE, BAUD_CODE);
    cmd(CMD_INFO, CMD_INFO);
    for (int i = 0; i < 4; i++) get((8'hF0 + 8'(i)) ^ 8'hA5);
    cmd(8'h77, 8'h71);
    put(CMD_SUM, 1'b1); get(8'h78);
    cmd(CMD_PROG, 8'h54);
    cmd(CMD_SUM, CMD_SUM);
    s = 16'h0000;
    for (int i = 0; i < 16; i++) s += {8'h00, 8'(i) ^ 8'hA5};
    get(s[15:8]); get(s[7:0]);
    cmd(CMD_PSET, CMD_PSET); pw(8'h01, 8'h00); get(8'h61);
    erase();
    `CHK(erased, 1'b1)
    cmd(CMD_PSET, CMD_PSET); pw(8'h00, 8'h01); get(8'h61);
    cmd(CMD_PSET, CMD_PSET); pw(8'h00, 8'h00); get(CMD_PSET);
    get(PS_OK); get(PD_OK);
    `CHK(prot_wr, 1'b1)
    cmd(CMD_PROG, 8'h56);
    cmd(CMD_RAM, 8'h16);
    erase();
    cmd(CMD_PROG, CMD_PROG); q = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02}; blk(8'h00); get(CMD_PROG);
    q = '{8'hAA, 8'h55}; blk(8'h00); get(CMD_PROG);
    cmd(CMD_PROG, CMD_PROG); q = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h02}; blk(8'h00); get(8'h51);
    // RAM transfer last: the handler hands over control and goes quiet
    cmd(CMD_RAM, CMD_RAM); pw(8'h00, 8'h00); get(CMD_RAM);
    q = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02}; blk(8'h00); get(CMD_RAM);
    q = '{8'h3C, 8'hC3}; blk(8'h00); get(CMD_RAM);
    repeat (4) @(posedge core_clk);
    `CHK(ram_n, 2)
    `CHK(execs, 1)
    conclude();
  end
endmodule
